// file: rtl/dpc_pin_cmd.sv
// DDR2 pin level command decoder, bank state, burst engine and storage
`timescale 1ns/1ns
`default_nettype none
module dpc_pin_cmd
  import dpc_pkg::*;
#(
  parameter int BURST_LEN = 4,
  parameter int CAS_LAT   = 3,
  parameter int ROW_BITS  = 2
)
(
  input  wire logic                sys_clk_in,
  input  wire logic                rst_n_in,
  input  wire logic                ck_in,
  input  wire logic                cke_in,
  input  wire logic                cs_n_in,
  input  wire logic                ras_n_in,
  input  wire logic                cas_n_in,
  input  wire logic                we_n_in,
  input  wire logic [BA_W-1:0]     ba_in,
  input  wire logic [ROW_W-1:0]    addr_in,
  input  wire logic [LANES-1:0]    dm_in,
  input  wire logic [DQ_W-1:0]     dq_in,
  input  wire logic [LANES-1:0]    dqs_in,
  output logic [DQ_W-1:0]          dq_rise_out,
  output logic [DQ_W-1:0]          dq_fall_out,
  output logic                     dq_oe_out,
  output logic [LANES-1:0]         dqs_rise_out,
  output logic                     dqs_oe_out,
  output logic                     dqs_n_oe_out,
  output logic [NUM_BANK-1:0]      bank_busy_out,
  output logic                     power_down_out
);
  localparam int KW     = (BURST_LEN > 4) ? 2 : 1;
  localparam int BW     = KW + 1;
  localparam int MEM_AW = BA_W + ROW_BITS + COL_W - 1;

  typedef struct packed {
    logic                            cke;
    logic                            pwr_down;
    logic [NUM_BANK-1:0]             open;
    logic [NUM_BANK-1:0][ROW_W-1:0]  row;
    logic [NUM_BANK-1:0][PRE_W-1:0]  pre;
    logic                            strobe_se;
    logic [3:0]                      lat;
    logic [BW-1:0]                   beat;
    logic [KW-1:0]                   k;
    logic                            wr;
    logic                            ap;
    logic [BA_W-1:0]                 bank;
    logic [COL_W-1:0]                col;
    logic [DQ_W-1:0]                 dq_r;
    logic [DQ_W-1:0]                 dq_f;
    logic                            dq_oe;
    logic                            dqs_oe;
    logic                            dqs_n_oe;
  } dpc_state_t;

  dpc_state_t              s_r;
  dpc_state_t              s_nxt;
  logic [2*DQ_W-1:0]       mem [2**MEM_AW];
  logic [2*DQ_W-1:0]       rd_word;
  logic [MEM_AW-1:0]       mem_idx;
  logic [2*DQ_W-1:0]       din_dq;
  logic [2*LANES-1:0]      din_dm;
  logic [LANES-1:0]        din_ok;
  logic [2*LANES-1:0]      wr_be;
  logic                    wr_beat;
  logic                    cmd_ok;
  logic [2:0]              cmd;
  logic [7:0]              old_byte;

  dpc_stat_if st_if ();

  // ---------------------------------------------------------------
  // Storage index of one word pair within the burst
  // ---------------------------------------------------------------
  function automatic logic [MEM_AW-1:0] mem_index(
    input logic [BA_W-1:0]     bank,
    input logic [ROW_W-1:0]    row,
    input logic [COL_W-1:0]    col,
    input logic [KW-1:0]       k
  );
    logic [COL_W-2:0] pair;
    pair         = col[COL_W-1:1];
    pair[KW-1:0] = pair[KW-1:0] + k;
    return {bank, row[ROW_BITS-1:0], pair};
  endfunction : mem_index

  // ---------------------------------------------------------------
  // Write capture and status crossing
  // ---------------------------------------------------------------
  dpc_ddr_in u_ddr_in (
    .ck_in       (ck_in),
    .rst_n_in    (rst_n_in),
    .dq_in       (dq_in),
    .dm_in       (dm_in),
    .dqs_in      (dqs_in),
    .pair_dq_out (din_dq),
    .pair_dm_out (din_dm),
    .lane_ok_out (din_ok)
  );

  dpc_status_sync u_sync (
    .sys_clk_in     (sys_clk_in),
    .rst_n_in       (rst_n_in),
    .st             (st_if.dst),
    .bank_busy_out  (bank_busy_out),
    .power_down_out (power_down_out)
  );

  assign st_if.bank_open = s_r.open;
  assign st_if.pwr_down  = s_r.pwr_down;

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  assign cmd     = {ras_n_in, cas_n_in, we_n_in};
  assign cmd_ok  = s_r.cke & cke_in & ~cs_n_in;
  assign mem_idx = mem_index(s_r.bank, s_r.row[s_r.bank], s_r.col, s_r.k);
  assign rd_word = mem[mem_idx];
  assign wr_be   = ~din_dm & {din_ok[1], din_ok[0], din_ok[1], din_ok[0]};
  assign old_byte = rd_word[7:0];

  always_comb
  begin
    s_nxt          = s_r;
    wr_beat        = 1'b0;
    s_nxt.cke      = cke_in;
    s_nxt.pwr_down = ~cke_in & ~|s_r.open;
    if (s_r.cke)
    begin
      for (int b = 0; b < NUM_BANK; b++)
      begin
        if (s_r.pre[b] != '0)
        begin
          s_nxt.pre[b] = s_r.pre[b] - 1'b1;
          if (s_r.pre[b] == PRE_W'(1))
            s_nxt.open[b] = 1'b0;
        end
      end
      s_nxt.dq_oe    = 1'b0;
      s_nxt.dqs_oe   = 1'b0;
      s_nxt.dqs_n_oe = 1'b0;
      if (s_r.lat != 4'h0)
        s_nxt.lat = s_r.lat - 4'h1;
      else if (s_r.beat != '0)
      begin
        s_nxt.beat = s_r.beat - 1'b1;
        s_nxt.k    = s_r.k + 1'b1;
        if (s_r.wr)
          wr_beat = 1'b1;
        else
        begin
          s_nxt.dq_r     = rd_word[DQ_W-1:0];
          s_nxt.dq_f     = rd_word[2*DQ_W-1:DQ_W];
          s_nxt.dq_oe    = 1'b1;
          s_nxt.dqs_oe   = 1'b1;
          s_nxt.dqs_n_oe = ~s_r.strobe_se;
        end
        if (s_r.beat == BW'(1) && s_r.ap)
          s_nxt.pre[s_r.bank] = PRE_CYC;
      end
      if (cmd_ok)
      begin
        case (cmd)
          CMD_ACT:
          begin
            s_nxt.open[ba_in] = 1'b1;
            s_nxt.row[ba_in]  = addr_in;
          end
          CMD_PRE:
          begin
            for (int b = 0; b < NUM_BANK; b++)
            begin
              if (s_r.open[b] && (addr_in[AP_BIT] || ba_in == BA_W'(b)))
                s_nxt.pre[b] = PRE_CYC;
            end
          end
          CMD_RD, CMD_WR:
          begin
            if (s_r.open[ba_in])
            begin
              s_nxt.wr   = ~we_n_in;
              s_nxt.lat  = we_n_in ? 4'(CAS_LAT - 1) : 4'(CAS_LAT);
              s_nxt.beat = BW'(BURST_LEN / 2);
              s_nxt.k    = '0;
              s_nxt.bank = ba_in;
              s_nxt.col  = addr_in[COL_W-1:0];
              s_nxt.ap   = addr_in[AP_BIT];
            end
          end
          CMD_MRS:
          begin
            if (ba_in == EMR1_SEL)
              s_nxt.strobe_se = addr_in[EMR_STROBE_BIT];
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge ck_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s_r           <= '0;
      s_r.strobe_se <= STROBE_SE_RST;
    end
    else
      s_r <= s_nxt;
  end

  // ---------------------------------------------------------------
  // Storage write with byte masking
  // ---------------------------------------------------------------
  always_ff @(posedge ck_in)
  begin
    if (wr_beat)
    begin
      for (int i = 0; i < 2 * LANES; i++)
      begin
        if (wr_be[i])
          mem[mem_idx][8*i +: 8] <= din_dq[8*i +: 8];
      end
    end
  end

  assign dq_rise_out  = s_r.dq_r;
  assign dq_fall_out  = s_r.dq_f;
  assign dq_oe_out    = s_r.dq_oe;
  assign dqs_rise_out = {LANES{s_r.dqs_oe}};
  assign dqs_oe_out   = s_r.dqs_oe;
  assign dqs_n_oe_out = s_r.dqs_n_oe;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ck_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_quiet;
    cke_in && s_r.cke && cs_n_in;
  endsequence
  sequence s_rd_cmd;
    cmd_ok && cmd == CMD_RD && s_r.open[ba_in];
  endsequence
  sequence s_wr_cmd;
    cmd_ok && cmd == CMD_WR && s_r.open[ba_in];
  endsequence

  property p_act;
    cmd_ok && cmd == CMD_ACT |=> s_r.open[$past(ba_in)] && s_r.row[$past(ba_in)] == $past(addr_in);
  endproperty
  a_act: assert property (p_act) else $error("activate did not open bank");

  property p_cs;
    s_r.cke && cke_in && cs_n_in && s_r.pre == '0 |=> $stable(s_r.open) && $stable(s_r.strobe_se);
  endproperty
  a_cs: assert property (p_cs) else $error("command taken with chip select high");

  property p_frz;
    !s_r.cke |=> $stable(dq_rise_out) && $stable(dq_oe_out) && $stable(s_r.beat);
  endproperty
  a_frz: assert property (p_frz) else $error("state moved while clock suspended");

  property p_rd;
    s_rd_cmd ##1 s_quiet [*3] |=> dq_oe_out && dqs_oe_out;
  endproperty
  a_rd: assert property (p_rd) else $error("read data not driven at latency");

  property p_wr;
    s_wr_cmd ##1 s_quiet [*3] |=> wr_beat && !dq_oe_out;
  endproperty
  a_wr: assert property (p_wr) else $error("write beat missing at latency");

  property p_mask;
    wr_beat && din_dm[1] |=> mem[$past(mem_idx)][15:8] == $past(rd_word[15:8]);
  endproperty
  a_mask: assert property (p_mask) else $error("masked byte was written");

  property p_pre_all;
    cmd_ok && cmd == CMD_PRE && addr_in[AP_BIT] ##1 s_quiet [*2] |=> s_r.open == '0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("banks not idle after precharge");

  property p_strb;
    dqs_n_oe_out |-> dqs_oe_out && !$past(s_r.strobe_se);
  endproperty
  a_strb: assert property (p_strb) else $error("complement strobe driven while disabled");

  property p_lane;
    wr_beat && !din_ok[0] |=> mem[$past(mem_idx)][7:0] == $past(old_byte)
      && mem[$past(mem_idx)][23:16] == $past(rd_word[23:16]);
  endproperty
  a_lane: assert property (p_lane) else $error("low lane written without its strobe");

  property p_pd;
    s_r.pwr_down |-> $past(s_r.open) == '0 && !$past(cke_in);
  endproperty
  a_pd: assert property (p_pd) else $error("power down with an open bank");
endmodule : dpc_pin_cmd
`default_nettype wire

// file: shared/dpc_pkg.sv
// Constants shared by the DDR2 pin command interface
package dpc_pkg;
  // ---------------------------------------------------------------
  // Pin widths
  // ---------------------------------------------------------------
  localparam int NUM_BANK = 4;
  localparam int BA_W     = 2;
  localparam int ROW_W    = 13;
  localparam int COL_W    = 10;
  localparam int DQ_W     = 16;
  localparam int LANES    = 2;
  localparam int SYNC_W   = NUM_BANK + 1;
  // ---------------------------------------------------------------
  // Command codes on {row strobe, column strobe, write enable}
  // ---------------------------------------------------------------
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_MRS = 3'h0;
  // ---------------------------------------------------------------
  // Field positions and mode register select
  // ---------------------------------------------------------------
  localparam int             AP_BIT         = 10;
  localparam int             EMR_STROBE_BIT = 10;
  localparam logic [BA_W-1:0] EMR1_SEL      = 2'h1;
  localparam logic           STROBE_SE_RST  = 1'h0;
  // ---------------------------------------------------------------
  // Timing counts in link clock cycles
  // ---------------------------------------------------------------
  localparam int             PRE_W   = 2;
  localparam logic [PRE_W-1:0] PRE_CYC = 2'h2;
endpackage : dpc_pkg

// file: shared/dpc_stat_if.sv
// Status carried from the link clock domain to the system clock domain
`timescale 1ns/1ns
`default_nettype none
interface dpc_stat_if;
  logic [3:0] bank_open;
  logic       pwr_down;
  modport src (output bank_open, output pwr_down);
  modport dst (input bank_open, input pwr_down);
endinterface : dpc_stat_if
`default_nettype wire

// file: rtl/dpc_status_sync.sv
// Three stage synchroniser of link status into the system clock domain
`timescale 1ns/1ns
`default_nettype none
module dpc_status_sync
  import dpc_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  dpc_stat_if.dst          st,
  output logic [3:0]       bank_busy_out,
  output logic             power_down_out
);
  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] q;
  } dpc_sync_t;

  dpc_sync_t s_r;
  dpc_sync_t s_nxt;
  logic [SYNC_W-1:0] diff;

  // ---------------------------------------------------------------
  // A bit changes only once stages two and three agree
  // ---------------------------------------------------------------
  always_comb
  begin
    s_nxt    = s_r;
    s_nxt.s1 = {st.pwr_down, st.bank_open};
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    diff     = s_r.s2 ^ s_r.s3;
    s_nxt.q  = (s_r.s3 & ~diff) | (s_r.q & diff);
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign bank_busy_out  = s_r.q[NUM_BANK-1:0];
  assign power_down_out = s_r.q[NUM_BANK];
endmodule : dpc_status_sync
`default_nettype wire

// file: rtl/dpc_ddr_in.sv
// Double data rate capture of write data and masks, with strobe levels taken at the rising edge only
`timescale 1ns/1ns
`default_nettype none
module dpc_ddr_in
  import dpc_pkg::*;
(
  input  wire logic                ck_in,
  input  wire logic                rst_n_in,
  input  wire logic [DQ_W-1:0]     dq_in,
  input  wire logic [LANES-1:0]    dm_in,
  input  wire logic [LANES-1:0]    dqs_in,
  output logic [2*DQ_W-1:0]        pair_dq_out,
  output logic [2*LANES-1:0]       pair_dm_out,
  output logic [LANES-1:0]         lane_ok_out
);
  logic [DQ_W+2*LANES-1:0] rise_r;
  logic [DQ_W+2*LANES-1:0] hold_r;
  logic [DQ_W+LANES-1:0]   fall_r;

  // ---------------------------------------------------------------
  // Even word at the rising crossing, odd word at the falling one
  // ---------------------------------------------------------------
  always_ff @(negedge ck_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fall_r <= '0;
      hold_r <= '0;
    end
    else
    begin
      fall_r <= {dq_in, dm_in};
      hold_r <= rise_r;
    end
  end

  always_ff @(posedge ck_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rise_r      <= '0;
      pair_dq_out <= '0;
      pair_dm_out <= '0;
      lane_ok_out <= '0;
    end
    else
    begin
      rise_r      <= {dq_in, dm_in, dqs_in};
      pair_dq_out <= {fall_r[DQ_W+LANES-1:LANES], hold_r[DQ_W+2*LANES-1:2*LANES]};
      pair_dm_out <= {fall_r[LANES-1:0], hold_r[2*LANES-1:LANES]};
      lane_ok_out <= hold_r[LANES-1:0];
    end
  end
endmodule : dpc_ddr_in
`default_nettype wire

// file: sim/dpc_ctrl_model.sv
// Memory controller model driving the DDR2 command and data pins
`timescale 1ns/1ns
`default_nettype none
module dpc_ctrl_model
  import dpc_pkg::*;
(
  input  wire logic         ck_in,
  output logic              cke_out,
  output logic              cs_n_out,
  output logic [2:0]        cmd_out,
  output logic [BA_W-1:0]   ba_out,
  output logic [ROW_W-1:0]  addr_out,
  output logic [LANES-1:0]  dm_out,
  output logic [DQ_W-1:0]   dq_out,
  output logic [LANES-1:0]  dqs_out
);
  logic wr_on = 1'h0;
  initial
  begin
    cke_out  = 1'h1;
    cs_n_out = 1'h1;
    cmd_out  = 3'h7;
    ba_out   = '0;
    addr_out = '0;
    dm_out   = '0;
    dq_out   = '0;
    dqs_out  = '0;
  end
  // Released lines keep changing so stale data never looks valid
  always @(posedge ck_in)
    if (!wr_on)
    begin
      dq_out  <= ~dq_out;
      dqs_out <= ~dqs_out;
      dm_out  <= ~dm_out;
    end
  task automatic set_cke(input logic v);
    @(posedge ck_in);
    #5;
    cke_out = v;
  endtask : set_cke
  // Levels change just after a rise and hold through the next rise
  task automatic cmd(input logic cs_n, input logic [2:0] c,
                     input logic [BA_W-1:0] b, input logic [ROW_W-1:0] a);
    @(posedge ck_in);
    #5;
    cs_n_out = cs_n;
    cmd_out  = c;
    ba_out   = b;
    addr_out = a;
    @(posedge ck_in);
    #5;
    cs_n_out = 1'h1;
    cmd_out  = 3'h7;
  endtask : cmd
  // Each word is set half a cycle before the edge that takes it
  task automatic wr(input logic [BA_W-1:0] b, input logic [ROW_W-1:0] a,
                    input logic [4*DQ_W-1:0] d, input logic [7:0] m,
                    input logic [3:0] s);
    int i;
    wr_on = 1'h1;
    cmd(1'h0, CMD_WR, b, a);
    @(posedge ck_in);
    for (i = 0; i < 4; i++)
    begin
      if (i[0])
        @(posedge ck_in);
      else
        @(negedge ck_in);
      #5;
      dq_out = d[i*DQ_W +: DQ_W];
      dm_out = m[2*i +: 2];
      if (!i[0])
        dqs_out = s[i +: 2];
    end
    @(posedge ck_in);
    #5;
    wr_on = 1'h0;
  endtask : wr
endmodule : dpc_ctrl_model
`default_nettype wire

// file: sim/dpc_pin_cmd_test.sv
// Self-checking bench for the DDR2 pin command interface
`timescale 1ns/1ns
`default_nettype none
module dpc_pin_cmd_test;
  import dpc_pkg::*;
  localparam logic [63:0] DW = 64'h7081_5E6F_3C4D_1A2B;
  localparam logic [63:0] EW = 64'hA7B8_9586_E3F4_C1D2;
  localparam logic [63:0] MX = 64'hA74D_952B_E3F4_5ED2;
  logic                sys_clk_in = 1'h0;
  logic                ck         = 1'h0;
  logic                rst_n      = 1'h0;
  logic                cke;
  logic                cs_n;
  logic [2:0]          cmd;
  logic [BA_W-1:0]     ba;
  logic [ROW_W-1:0]    addr;
  logic [LANES-1:0]    dm;
  logic [DQ_W-1:0]     dq;
  logic [LANES-1:0]    dqs;
  logic [DQ_W-1:0]     dq_rise;
  logic [DQ_W-1:0]     dq_fall;
  logic                dq_oe;
  logic [LANES-1:0]    dqs_rise;
  logic                dqs_oe;
  logic                dqs_n_oe;
  logic [NUM_BANK-1:0] busy;
  logic                pdn;
  int                  num_errors = 0;
  int                  n_compared = 0;
  int                  cyc        = 0;
  always #25 sys_clk_in = ~sys_clk_in;
  initial
  begin
    #7;
    forever #40 ck = ~ck;
  end
  dpc_ctrl_model m (
    .ck_in(ck), .cke_out(cke), .cs_n_out(cs_n), .cmd_out(cmd), .ba_out(ba),
    .addr_out(addr), .dm_out(dm), .dq_out(dq), .dqs_out(dqs)
  );
  dpc_pin_cmd uut (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n), .ck_in(ck), .cke_in(cke),
    .cs_n_in(cs_n), .ras_n_in(cmd[2]), .cas_n_in(cmd[1]), .we_n_in(cmd[0]),
    .ba_in(ba), .addr_in(addr), .dm_in(dm), .dq_in(dq), .dqs_in(dqs),
    .dq_rise_out(dq_rise), .dq_fall_out(dq_fall), .dq_oe_out(dq_oe),
    .dqs_rise_out(dqs_rise), .dqs_oe_out(dqs_oe), .dqs_n_oe_out(dqs_n_oe),
    .bank_busy_out(busy), .power_down_out(pdn)
  );
  task automatic summarize;
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic ek(input int n);
    repeat (n) @(posedge ck);
    #5;
  endtask : ek
  // Status needs a few system edges to cross
  task automatic sw;
    repeat (12) @(posedge sys_clk_in);
    #5;
  endtask : sw
  task automatic rd_chk(input logic [ROW_W-1:0] a, input logic [63:0] e,
                        input logic diff);
    m.cmd(1'h0, CMD_RD, 2'h1, a);
    ek(3);
    chk(16'(dq_oe), 16'h1);
    chk(16'(dqs_oe), 16'h1);
    chk(16'(dqs_rise), 16'h3);
    chk(16'(dqs_n_oe), 16'(diff));
    chk(dq_rise, e[15:0]);
    chk(dq_fall, e[31:16]);
    ek(1);
    chk(dq_rise, e[47:32]);
    chk(dq_fall, e[63:48]);
    ek(1);
    chk(16'(dq_oe), 16'h0);
  endtask : rd_chk
  task automatic t_bank;
    m.cmd(1'h1, CMD_ACT, 2'h1, 13'h0001);
    sw();
    chk(16'(busy), 16'h0);
    m.cmd(1'h0, CMD_ACT, 2'h1, 13'h0001);
    sw();
    chk(16'(busy), 16'h2);
  endtask : t_bank
  task automatic t_wrap;
    m.wr(2'h1, 13'h0002, DW, 8'h00, 4'hF);
    rd_chk(13'h0000, 64'h3C4D_1A2B_7081_5E6F, 1'h1);
  endtask : t_wrap
  task automatic t_mask;
    m.wr(2'h1, 13'h0000, EW, 8'h02, 4'hB);
    rd_chk(13'h0000, MX, 1'h1);
  endtask : t_mask
  task automatic t_strobe;
    m.cmd(1'h0, CMD_MRS, 2'h2, 13'h0400);
    rd_chk(13'h0000, MX, 1'h1);
    m.cmd(1'h0, CMD_MRS, EMR1_SEL, 13'h0400);
    rd_chk(13'h0000, MX, 1'h0);
  endtask : t_strobe
  task automatic t_cke;
    m.cmd(1'h0, CMD_RD, 2'h1, 13'h0000);
    ek(2);
    m.set_cke(1'h0);
    ek(3);
    chk(16'(dq_oe), 16'h1);
    chk(dq_rise, MX[47:32]);
    sw();
    chk(16'(pdn), 16'h0);
    m.set_cke(1'h1);
    ek(4);
    chk(16'(dq_oe), 16'h0);
  endtask : t_cke
  task automatic t_pre;
    m.cmd(1'h0, CMD_ACT, 2'h2, 13'h0003);
    sw();
    chk(16'(busy), 16'h6);
    m.wr(2'h2, 13'h0400, DW, 8'h00, 4'hF);
    sw();
    chk(16'(busy), 16'h2);
    m.cmd(1'h0, CMD_PRE, 2'h1, 13'h0000);
    sw();
    chk(16'(busy), 16'h0);
    m.cmd(1'h0, CMD_ACT, 2'h0, 13'h1FFF);
    m.cmd(1'h0, CMD_ACT, 2'h3, 13'h0002);
    sw();
    chk(16'(busy), 16'h9);
    m.cmd(1'h0, CMD_PRE, 2'h1, 13'h0400);
    sw();
    chk(16'(busy), 16'h0);
  endtask : t_pre
  task automatic t_pdn;
    m.set_cke(1'h0);
    sw();
    chk(16'(pdn), 16'h1);
    m.set_cke(1'h1);
    sw();
    chk(16'(pdn), 16'h0);
  endtask : t_pdn
  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      num_errors++;
      summarize();
    end
  end
  initial
  begin
    repeat (16) @(posedge sys_clk_in);
    #5;
    rst_n = 1'h1;
    ek(4);
    t_bank();
    t_wrap();
    t_mask();
    t_strobe();
    t_cke();
    t_pre();
    t_pdn();
    summarize();
  end
endmodule : dpc_pin_cmd_test
`default_nettype wire
